/* File: hdl/board_control_apb_registers.sv */
// Board control register bank on the peripheral bus: clock generator divisors with
// a key lock, user LEDs, push-button latch, DIP switch readback and display mux control.
// Assumes an APB bridge master on mclk and pin-side inputs already synchronous, except
// the push button, which is brought in through two flops here.
//
// Behaviour
// - APB slave decodes registers at word offsets
// - Two divisor registers program two generators
// - Key write to lock register unlocks divisors
// - Any other lock write relocks divisors
// - Locked divisor registers ignore writes
// - Lock bit 16 reads lock state
// - Key field 15:0 read/write, must hold key
// - Divisor bits 15:9 drive reference divider pins
// - Divisor bits 8:0 drive VCO divider pins
// - Reset divisors give 25 and 48 MHz
// - LED bit written zero lights its LED
// - Button latch single bit, sticky until cleared
// - Latched bit drives interrupt request directly
// - Writing zero clears the button latch
// - Writing one sets latch like press
// - Switches register read-only, eight switch bits
// - Closed switch reads zero, open reads one
// - Display enable bit 2, resets to one
// - Display select bits 1:0, reset flat panel
`timescale 1ns/1ps
`include "board_ctrl_cfg.svh"

module board_control_apb_registers
  import board_ctrl_pkg::*;
#(
  parameter int LED_COUNT = 8,
  parameter int SW_COUNT  = 8
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // First clock generator pins
  output logic      [2:0]           oscOneOutputDividerCode,
  output logic      [6:0]           oscOneReferenceDividerWord,
  output logic      [8:0]           oscOneVcoDividerWord,
  // Second clock generator pins
  output logic      [2:0]           oscTwoOutputDividerCode,
  output logic      [6:0]           oscTwoReferenceDividerWord,
  output logic      [8:0]           oscTwoVcoDividerWord,
  // User LEDs, active low
  output logic      [LED_COUNT-1:0] userLedN,
  // Push button and interrupt request
  input  wire logic                 buttonPressed,
  output logic                      buttonIrq,
  // DIP switch, low when closed
  input  wire logic [SW_COUNT-1:0]  dipSwitchN,
  // Display mux control
  output logic                      displayEnable,
  output display_sel_t              displaySelect
);

  // Stored register state
  logic [18:0]          oscOneDivisor_q;
  logic [18:0]          oscTwoDivisor_q;
  logic [15:0]          unlockKeyField_q;
  logic [LED_COUNT-1:0] userLedControl_q;
  logic                 buttonIrqLatch_q;
  logic                 displayEnable_q;
  display_sel_t         displaySelect_q;

  // Button synchroniser, edge detector and latch next value
  logic                 buttonSync1_q;
  logic                 buttonSync2_q;
  logic                 buttonPrev_q;
  logic                 buttonEdge;
  logic                 buttonLatch_d;

  // Bus phase strobes
  logic                 wrAccess;
  logic                 rdAccess;

  // Offset decode, one select per register
  logic                 hitOscOne;
  logic                 hitOscTwo;
  logic                 hitLock;
  logic                 hitLeds;
  logic                 hitButton;
  logic                 hitSwitches;
  logic                 hitDisplay;
  logic                 mapped;

  // Per-register write enables
  logic                 wrOscOne;
  logic                 wrOscTwo;
  logic                 wrLock;
  logic                 wrLeds;
  logic                 wrButton;
  logic                 wrDisplay;

  // Lock state and read path
  logic                 keyMatch;
  logic                 locked;
  logic [31:0]          readMux;

  // Zero-wait-state slave: nothing here ever stalls, so pready is tied high.
  // No error is ever flagged; a locked divisor write is dropped silently, so
  // software that forgets to unlock only finds out by reading back.
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  // Write lands at the access-phase edge; read data is fetched at the
  // setup-phase edge so prdata already stands when the access phase is sampled
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & ~penable & ~pwrite;

  // Offset decode; an if/else-if chain keeps the selects one-hot.
  // Only the low address bits reach this block; the base is decoded upstream.
  always_comb begin
    hitOscOne   = 1'b0;
    hitOscTwo   = 1'b0;
    hitLock     = 1'b0;
    hitLeds     = 1'b0;
    hitButton   = 1'b0;
    hitSwitches = 1'b0;
    hitDisplay  = 1'b0;
    mapped      = 1'b1;
    if (paddr == `OFS_OSC_ONE) begin
      hitOscOne = 1'b1;
    end else if (paddr == `OFS_OSC_TWO) begin
      hitOscTwo = 1'b1;
    end else if (paddr == `OFS_LOCK) begin
      hitLock = 1'b1;
    end else if (paddr == `OFS_LEDS) begin
      hitLeds = 1'b1;
    end else if (paddr == `OFS_BUTTON) begin
      hitButton = 1'b1;
    end else if (paddr == `OFS_SWITCHES) begin
      hitSwitches = 1'b1;
    end else if (paddr == `OFS_DISPLAY) begin
      hitDisplay = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Per-register write enables. The switches register has none, so a write
  // to it is simply lost, as is a write to an unmapped offset.
  assign wrOscOne  = wrAccess & hitOscOne;
  assign wrOscTwo  = wrAccess & hitOscTwo;
  assign wrLock    = wrAccess & hitLock;
  assign wrLeds    = wrAccess & hitLeds;
  assign wrButton  = wrAccess & hitButton;
  assign wrDisplay = wrAccess & hitDisplay;

  // Lock state follows the stored key field, so reset (key cleared) is locked.
  // The whole 16-bit field must match; a match on the low byte alone is not
  // enough, which makes an accidental unlock by a stray write less likely.
  assign keyMatch = (unlockKeyField_q == `LOCK_KEY);
  assign locked   = ~keyMatch;

  // First divisor; writes dropped silently while locked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscOneDivisor_q <= `OSC_ONE_RESET;
    end else if (wrOscOne && !locked) begin
      oscOneDivisor_q <= pwdata[18:0];
    end
  end

  // Second divisor, same guard. Bits above 18 are not stored and read zero.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscTwoDivisor_q <= `OSC_TWO_RESET;
    end else if (wrOscTwo && !locked) begin
      oscTwoDivisor_q <= pwdata[18:0];
    end
  end

  // Key field: any write stores the low half, only the key value unlocks.
  // The upper half of the written word is dropped; bit 16 reads the state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unlockKeyField_q <= `LOCK_KEY_RESET;
    end else if (wrLock) begin
      unlockKeyField_q <= pwdata[15:0];
    end
  end

  // LED register; the reset value keeps every LED dark
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      userLedControl_q <= LED_COUNT'(`LED_RESET);
    end else if (wrLeds) begin
      userLedControl_q <= pwdata[LED_COUNT-1:0];
    end
  end

  // Display enable bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      displayEnable_q <= `DISPLAY_EN_RESET;
    end else if (wrDisplay) begin
      displayEnable_q <= pwdata[2];
    end
  end

  // Display select; every code is legal, so no filtering is needed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      displaySelect_q <= display_sel_t'(`DISPLAY_SEL_RESET);
    end else if (wrDisplay) begin
      displaySelect_q <= display_sel_t'(pwdata[1:0]);
    end
  end

  // Button synchroniser. The first stage may go metastable, so only the
  // second stage is read by anything else.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buttonSync1_q <= 1'b0;
      buttonSync2_q <= 1'b0;
    end else begin
      buttonSync1_q <= buttonPressed;
      buttonSync2_q <= buttonSync1_q;
    end
  end

  // Edge detector history; resets to the idle level of the button so that
  // leaving reset never looks like a press
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buttonPrev_q <= 1'b0;
    end else begin
      buttonPrev_q <= buttonSync2_q;
    end
  end

  // Rising edge of the synchronised button; a held button latches only once
  assign buttonEdge = buttonSync2_q & ~buttonPrev_q;

  // Latch next value: a press in the clearing cycle wins over the clear,
  // so a press that races the handler's clear is never lost
  always_comb begin
    buttonLatch_d = buttonIrqLatch_q;
    if (wrButton) begin
      buttonLatch_d = pwdata[0];
    end
    if (buttonEdge) begin
      buttonLatch_d = 1'b1;
    end
  end

  // Latch register, driven straight out as the interrupt request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buttonIrqLatch_q <= 1'b0;
    end else begin
      buttonIrqLatch_q <= buttonLatch_d;
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitOscOne) begin
      readMux[18:0] = oscOneDivisor_q;
    end else if (hitOscTwo) begin
      readMux[18:0] = oscTwoDivisor_q;
    end else if (hitLock) begin
      readMux[`LOCK_STATE_BIT] = locked;
      readMux[15:0]            = unlockKeyField_q;
    end else if (hitLeds) begin
      readMux[LED_COUNT-1:0] = userLedControl_q;
    end else if (hitButton) begin
      readMux[0] = buttonIrqLatch_q;
    end else if (hitSwitches) begin
      readMux[SW_COUNT-1:0] = dipSwitchN;
    end else if (hitDisplay) begin
      readMux[2]   = displayEnable_q;
      readMux[1:0] = displaySelect_q;
    end
  end

  // Read data registered in the setup phase and held through the access
  // phase. Trade-off: a value that changes between the two phases is read as
  // it stood at setup, which keeps prdata glitch-free for the master.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (rdAccess) begin
      prdata <= mapped ? readMux : 32'h0000_0000;
    end
  end

  // First generator pins straight from its divisor register
  assign oscOneOutputDividerCode    = oscOneDivisor_q[`DIV_OD_HI:`DIV_OD_LO];
  assign oscOneReferenceDividerWord = oscOneDivisor_q[`DIV_RDW_HI:`DIV_RDW_LO];
  assign oscOneVcoDividerWord       = oscOneDivisor_q[`DIV_VDW_HI:`DIV_VDW_LO];

  // Second generator pins; no range check, software keeps the VCO legal
  assign oscTwoOutputDividerCode    = oscTwoDivisor_q[`DIV_OD_HI:`DIV_OD_LO];
  assign oscTwoReferenceDividerWord = oscTwoDivisor_q[`DIV_RDW_HI:`DIV_RDW_LO];
  assign oscTwoVcoDividerWord       = oscTwoDivisor_q[`DIV_VDW_HI:`DIV_VDW_LO];

  // LEDs are active low, so the stored bit goes out unchanged
  assign userLedN      = userLedControl_q;

  // Interrupt request is the latch itself, with no masking here
  assign buttonIrq     = buttonIrqLatch_q;

  // Display mux control
  assign displayEnable = displayEnable_q;
  assign displaySelect = displaySelect_q;

endmodule : board_control_apb_registers

/* File: hdl/board_ctrl_cfg.svh */
// Offsets, field positions, reset values and key for the board control register bank.
// Assumes inclusion by bare name from the register bank module and the checker.
`ifndef BOARD_CTRL_CFG_SVH
`define BOARD_CTRL_CFG_SVH

// Register byte offsets
`define OFS_OSC_ONE        12'h000
`define OFS_OSC_TWO        12'h004
`define OFS_LOCK           12'h008
`define OFS_LEDS           12'h00C
`define OFS_BUTTON         12'h010
`define OFS_SWITCHES       12'h014
`define OFS_DISPLAY        12'h018

// Divisor field positions
`define DIV_OD_HI          18
`define DIV_OD_LO          16
`define DIV_RDW_HI         15
`define DIV_RDW_LO         9
`define DIV_VDW_HI         8
`define DIV_VDW_LO         0

// Lock register fields and key
`define LOCK_STATE_BIT     16
`define LOCK_KEY           16'hA05F

// Reset values: 48 MHz * (V+8) / ((R+2) * OD)
// 25 MHz: V=117, R=22, OD=10 -> 48*125/(24*10)=25
`define OSC_ONE_RESET      19'h02C75
// 48 MHz: V=12, R=8, OD=2 -> 48*20/(10*2)=48
`define OSC_TWO_RESET      19'h1100C
`define LOCK_KEY_RESET     16'h0000
`define LED_RESET          8'hFF
`define DISPLAY_EN_RESET   1'b1
`define DISPLAY_SEL_RESET  2'h0

`endif

/* File: hdl/board_ctrl_pkg.sv */
// Types shared by the board control register bank.
// Assumes the configuration header sits beside it.
package board_ctrl_pkg;

  // Display output path selection
  typedef enum logic [1:0] {
    DISP_FLAT_PANEL = 2'h0,
    DISP_MON_16BPP  = 2'h1,
    DISP_LCD_CONN   = 2'h2,
    DISP_MON_24BPP  = 2'h3
  } display_sel_t;

  // Output divider code
  typedef logic [2:0] output_divider_code_t;

endpackage : board_ctrl_pkg

/* File: verif/board_ctrl_checker.sv */
// Checker for the board control register bank, bound to the bank's ports.
// Assumes one clock domain and the bank's configuration header on the include path.
`timescale 1ns/1ps
`include "board_ctrl_cfg.svh"
module board_ctrl_checker
  import board_ctrl_pkg::*;
#(
  parameter int LED_COUNT = 8,
  parameter int SW_COUNT  = 8
) (
  // Clock, reset and APB
  input wire logic                 mclk, rstn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata, prdata,
  // Pin side
  input wire logic [2:0]           oscOneOutputDividerCode,
  input wire logic [6:0]           oscOneReferenceDividerWord,
  input wire logic [8:0]           oscOneVcoDividerWord,
  input wire logic [LED_COUNT-1:0] userLedN,
  input wire logic                 buttonPressed, buttonIrq, displayEnable,
  input wire logic [SW_COUNT-1:0]  dipSwitchN,
  input wire display_sel_t         displaySelect
);
  logic        wr, lockOpen_q;
  logic [18:0] oscOne;
  // Write strobe and first generator word
  assign wr = psel & penable & pwrite;
  assign oscOne = {oscOneOutputDividerCode, oscOneReferenceDividerWord, oscOneVcoDividerWord};
  // Own copy of the key state, so divisor writes can be judged without internals
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) lockOpen_q <= 1'b0;
    else if (wr && paddr == `OFS_LOCK) lockOpen_q <= pwdata[15:0] == `LOCK_KEY;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_BUS_OK: assert property (pready && !pslverr)
    else $error("bus answer not ready or flagged");
  AST_DIV_SET: assert property (wr && paddr == `OFS_OSC_ONE && lockOpen_q
    |=> oscOne == $past(pwdata[18:0])) else $error("open divisor write not on pins");
  AST_DIV_HOLD: assert property (wr && paddr == `OFS_OSC_ONE && !lockOpen_q
    |=> $stable(oscOne)) else $error("locked divisor changed");
  AST_LED: assert property (wr && paddr == `OFS_LEDS
    |=> userLedN == $past(pwdata[LED_COUNT-1:0])) else $error("led pins differ");
  AST_IRQ_SET: assert property (wr && paddr == `OFS_BUTTON && pwdata[0]
    |=> buttonIrq) else $error("button write one did not set");
  AST_IRQ_HOLD: assert property (buttonIrq && !(wr && paddr == `OFS_BUTTON)
    |=> buttonIrq) else $error("button request dropped");
  AST_PRESS: assert property ($rose(buttonPressed) |-> ##[2:4] buttonIrq)
    else $error("press not latched");
  AST_DISP: assert property (wr && paddr == `OFS_DISPLAY
    |=> {displayEnable, displaySelect} == $past(pwdata[2:0])) else $error("display pins differ");
  AST_SW: assert property (psel && !penable && !pwrite && paddr == `OFS_SWITCHES
    |=> prdata == 32'($past(dipSwitchN))) else $error("switch read differs");
endmodule : board_ctrl_checker
bind board_control_apb_registers board_ctrl_checker #(.LED_COUNT(LED_COUNT), .SW_COUNT(SW_COUNT))
  chk (.mclk, .rstn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata,
       .oscOneOutputDividerCode, .oscOneReferenceDividerWord, .oscOneVcoDividerWord, .userLedN,
       .buttonPressed, .buttonIrq, .displayEnable, .dipSwitchN, .displaySelect);

/* File: verif/apb_host_model.sv */
// Host-side APB master that reaches the register bank one transfer at a time.
// Assumes the bank answers on pready during the access phase.
`timescale 1ns/1ps
module apb_host_model (
  // Clock
  input  wire logic        mclk,
  // APB master side
  output logic             psel, penable, pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // Idle bus at time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Setup then access; released address and data are inverted so no stale value lingers
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic ok);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    ok = pready === 1'b1;
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host_model

/* File: verif/board_control_apb_registers_tb_top.sv */
// Self-checking bench for the board control register bank.
// Assumes the bound checker and the APB host model beside it.
`timescale 1ns/1ps
module board_control_apb_registers_tb_top
  import board_ctrl_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic         mclk, rstn, psel, penable, pwrite, pready, pslverr, buttonPressed;
  logic         buttonIrq, displayEnable;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [2:0]   oneOd, twoOd;
  logic [6:0]   oneRef, twoRef;
  logic [8:0]   oneVco, twoVco;
  logic [7:0]   userLedN, dipSwitchN;
  display_sel_t displaySelect;
  int           badCount = 0, nTests = 0, n;
  // Address, write data, read-back; the second divisor takes the first divisor's reset VCO and reference words
  row_t rows [14] = '{
    '{12'h008, 32'h0000A05F, 32'h0000A05F}, '{12'h000, 32'hFFFFFFFF, 32'h0007FFFF},
    '{12'h004, 32'h00032C75, 32'h00032C75}, '{12'h008, 32'h0001A05E, 32'h0001A05E},
    '{12'h000, 32'h00000000, 32'h0007FFFF}, '{12'h00C, 32'h000000A5, 32'h000000A5},
    '{12'h018, 32'h000000FB, 32'h00000003}, '{12'h018, 32'h00000005, 32'h00000005},
    '{12'h018, 32'h00000002, 32'h00000002}, '{12'h018, 32'h00000000, 32'h00000000},
    '{12'h014, 32'hFFFFFFFF, 32'h0000003C}, '{12'h01C, 32'hFFFFFFFF, 32'h00000000},
    '{12'h010, 32'h00000001, 32'h00000001}, '{12'h010, 32'h00000000, 32'h00000000}};
  board_control_apb_registers dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .oscOneOutputDividerCode(oneOd), .oscOneReferenceDividerWord(oneRef),
    .oscOneVcoDividerWord(oneVco), .oscTwoOutputDividerCode(twoOd), .oscTwoReferenceDividerWord(twoRef),
    .oscTwoVcoDividerWord(twoVco), .userLedN, .buttonPressed, .buttonIrq, .dipSwitchN,
    .displayEnable, .displaySelect);
  apb_host_model host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : printVerdict
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // A hung transfer ends the run at once
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(w, a, d, rd, ok);
    if (!ok) begin
      badCount++;
      printVerdict();
    end
  endtask : bus
  initial begin
    {mclk, rstn, buttonPressed} = 3'h0;
    dipSwitchN = 8'h3C;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // Write each row, then read it back
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      cmp("readback", rows[i].e, rd);
    end
    cmp("osc two pins", 32'h32C75, {twoOd, twoRef, twoVco});
    cmp("led pins", 32'hA5, userLedN);
    // Button press is latched and held after release until cleared
    buttonPressed <= 1'b1;
    for (n = 0; n < 8 && buttonIrq !== 1'b1; n++) @(posedge mclk);
    if (buttonIrq !== 1'b1) begin
      badCount++;
      printVerdict();
    end
    buttonPressed <= 1'b0;
    bus(1'b0, 12'h010, 32'h0);
    cmp("button irq", 32'h3, {buttonIrq, rd[0]});
    bus(1'b1, 12'h010, 32'h0);
    // The clear lands at the access edge; look one edge later, once it has settled
    @(posedge mclk);
    cmp("cleared irq", 32'h0, buttonIrq);
    // Second reset in mid-run restores every register
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    cmp("osc one reset", 32'h02C75, {oneOd, oneRef, oneVco});
    cmp("osc two reset", 32'h1100C, {twoOd, twoRef, twoVco});
    cmp("pins reset", 32'h7FC, {buttonIrq, userLedN, displayEnable, displaySelect});
    bus(1'b0, 12'h008, 32'h0);
    cmp("lock reset", 32'h00010000, rd);
    printVerdict();
  end
endmodule : board_control_apb_registers_tb_top
